// ### core/cca_defs.svh
`ifndef CCA_DEFS_SVH
`define CCA_DEFS_SVH
// Operation
// R1 - binary time counts, 24-hour hours
// R2 - month lengths, leap every fourth year
// R3 - packed time word, six year bits
// R4 - software rereads until two reads agree
// R5 - software reads back each write
// R6 - locked interface ignores all writes
// R7 - per-field alarm enables, all enabled match
// R8 - alarm sets status, irq when enabled
// R9 - writing one clears alarm status
// R10 - alarm registers writable at any time
// R11 - alarm compared once per second
// R12 - every alarm sends wake to power unit
// R13 - system reset keeps time, alarm, control
// R14 - no initial value assumed at power-up
// R15 - seconds six bits, max 59
// R16 - minutes six bits, max 59
// R17 - hours five bits, max 23
// R18 - day five bits, first day is one
// R19 - month four bits, one to twelve
// R20 - year eight bits, 1900 plus count
// R21 - oscillator divided to one-second tick
// R22 - oscillator input passes a synchroniser

`define CCA_ADDR_W     12
`define CCA_OFS_SEC    12'h000
`define CCA_OFS_MIN    12'h004
`define CCA_OFS_HRS    12'h008
`define CCA_OFS_DOM    12'h00c
`define CCA_OFS_MON    12'h010
`define CCA_OFS_YR     12'h014
`define CCA_OFS_TIME   12'h018
`define CCA_OFS_ASEC   12'h01c
`define CCA_OFS_AMIN   12'h020
`define CCA_OFS_AHRS   12'h024
`define CCA_OFS_ADOM   12'h028
`define CCA_OFS_AMON   12'h02c
`define CCA_OFS_AYR    12'h030
`define CCA_OFS_ACTRL  12'h034
`define CCA_OFS_CTRL   12'h038

`define CCA_CTRL_INT_EN 0
`define CCA_CTRL_STATUS 1
`define CCA_AEN_SEC    0
`define CCA_AEN_MIN    1
`define CCA_AEN_HRS    2
`define CCA_AEN_DOM    3
`define CCA_AEN_MON    4
`define CCA_AEN_YR     5

`define CCA_SEC_LAST   6'h3b
`define CCA_MIN_LAST   6'h3b
`define CCA_HRS_LAST   5'h17
`define CCA_MON_LAST   4'hc
`define CCA_MON_FIRST  4'h1
`define CCA_DOM_FIRST  5'h01
`define CCA_OSC_DIV    32768
`endif

// ### core/cca_pkg.sv
`default_nettype none
package cca_pkg;
  typedef logic [5:0] cca_sec_t;
  typedef logic [4:0] cca_hrs_t;
  typedef logic [4:0] cca_dom_t;
  typedef logic [3:0] cca_mon_t;
  typedef logic [7:0] cca_yr_t;
endpackage
`default_nettype wire

// ### core/cca_tick.sv
`timescale 1ns/10ps
`default_nettype none
module cca_tick #(
  parameter int DIV = 32768
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic osc_pin,
  output logic      tick
);
  localparam int CW = $clog2(DIV);

  logic          s1;
  logic          s2;
  logic          s3;
  logic          settled;
  logic [CW-1:0] cnt;
  logic          rise;

  // first stage is read only by the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= osc_pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a level counts only once stages two and three agree
  assign rise = (s2 == s3) && s3 && !settled; // R22

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      settled <= 1'b0;
    end else if (s2 == s3) begin
      settled <= s3;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (rise) begin
        if (cnt == CW'(DIV - 1)) begin
          cnt  <= '0;
          tick <= 1'b1; // R21
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### core/cca_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "cca_defs.svh"
module cca_top #(
  parameter int TICK_DIV = `CCA_OSC_DIV
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`CCA_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   osc_32k,
  input  wire logic                   write_lock,
  output logic                        alarm_irq,
  output logic                        power_management_unit_wake
);
  cca_pkg::cca_sec_t sec;
  cca_pkg::cca_sec_t min;
  cca_pkg::cca_hrs_t hrs;
  cca_pkg::cca_dom_t dom;
  cca_pkg::cca_mon_t mon;
  cca_pkg::cca_yr_t  yr;
  cca_pkg::cca_sec_t a_sec;
  cca_pkg::cca_sec_t a_min;
  cca_pkg::cca_hrs_t a_hrs;
  cca_pkg::cca_dom_t a_dom;
  cca_pkg::cca_mon_t a_mon;
  cca_pkg::cca_yr_t  a_yr;
  logic [5:0]        alarm_field_enables;
  logic              int_en;
  logic              status;
  logic              tick;
  logic              cmp_pending;
  logic [5:0]        field_eq;
  logic              fire;
  logic              wr_ok;
  logic              c_sec;
  logic              c_min;
  logic              c_hrs;
  logic              c_dom;
  logic              c_mon;
  logic [31:0]       next_prdata;
  logic              next_pslverr;

  // leap test on the low year bits also makes 1900 and 2100 leap
  function automatic cca_pkg::cca_dom_t days_in_month(
    input cca_pkg::cca_mon_t m,
    input cca_pkg::cca_yr_t  y
  );
    case (m)
      4'h2:    days_in_month = (y[1:0] == 2'h0) ? 5'h1d : 5'h1c; // R2
      4'h4,
      4'h6,
      4'h9,
      4'hb:    days_in_month = 5'h1e;
      default: days_in_month = 5'h1f;
    endcase
  endfunction

  function automatic logic is_write(input logic [`CCA_ADDR_W-1:0] a);
    is_write = wr_ok && (paddr == a);
  endfunction

  cca_tick #(
    .DIV     (TICK_DIV)
  ) u_tick (
    .clk     (clk),
    .rst     (rst),
    .osc_pin (osc_32k),
    .tick    (tick)
  );

  assign pready = 1'b1;
  assign wr_ok  = psel && penable && pwrite && !write_lock; // R6

  // >= rather than == so an out-of-range write still wraps
  assign c_sec = tick && (sec >= `CCA_SEC_LAST); // R15
  assign c_min = c_sec && (min >= `CCA_MIN_LAST); // R16
  assign c_hrs = c_min && (hrs >= `CCA_HRS_LAST); // R17
  assign c_dom = c_hrs && (dom >= days_in_month(mon, yr)); // R2
  assign c_mon = c_dom && (mon >= `CCA_MON_LAST); // R19

  // time registers have no reset: they survive system reset
  always_ff @(posedge clk) begin // R14
    if (is_write(`CCA_OFS_SEC)) begin
      sec <= pwdata[5:0]; // R13
    end else if (tick) begin
      sec <= c_sec ? 6'h00 : sec + 6'h01; // R21
    end
  end

  always_ff @(posedge clk) begin
    if (is_write(`CCA_OFS_MIN)) begin
      min <= pwdata[5:0];
    end else if (c_sec) begin
      min <= c_min ? 6'h00 : min + 6'h01; // R16
    end
  end

  always_ff @(posedge clk) begin
    if (is_write(`CCA_OFS_HRS)) begin
      hrs <= pwdata[4:0];
    end else if (c_min) begin
      hrs <= c_hrs ? 5'h00 : hrs + 5'h01; // R1
    end
  end

  always_ff @(posedge clk) begin
    if (is_write(`CCA_OFS_DOM)) begin
      dom <= pwdata[4:0];
    end else if (c_hrs) begin
      dom <= c_dom ? `CCA_DOM_FIRST : dom + 5'h01; // R18
    end
  end

  always_ff @(posedge clk) begin
    if (is_write(`CCA_OFS_MON)) begin
      mon <= pwdata[3:0];
    end else if (c_dom) begin
      mon <= c_mon ? `CCA_MON_FIRST : mon + 4'h1; // R19
    end
  end

  always_ff @(posedge clk) begin
    if (is_write(`CCA_OFS_YR)) begin
      yr <= pwdata[7:0];
    end else if (c_mon) begin
      yr <= yr + 8'h01; // R20
    end
  end

  // set-points and enables accept writes whatever the alarm state
  always_ff @(posedge clk) begin
    if (is_write(`CCA_OFS_ASEC)) a_sec <= pwdata[5:0]; // R10
    if (is_write(`CCA_OFS_AMIN)) a_min <= pwdata[5:0];
    if (is_write(`CCA_OFS_AHRS)) a_hrs <= pwdata[4:0];
    if (is_write(`CCA_OFS_ADOM)) a_dom <= pwdata[4:0];
    if (is_write(`CCA_OFS_AMON)) a_mon <= pwdata[3:0];
    if (is_write(`CCA_OFS_AYR))  a_yr  <= pwdata[7:0];
    if (is_write(`CCA_OFS_ACTRL)) begin
      alarm_field_enables <= pwdata[5:0];
    end
  end

  // compare the cycle after the tick, once the counts have settled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmp_pending <= 1'b0;
    end else begin
      cmp_pending <= tick; // R11
    end
  end

  assign field_eq[`CCA_AEN_SEC] = (sec == a_sec);
  assign field_eq[`CCA_AEN_MIN] = (min == a_min);
  assign field_eq[`CCA_AEN_HRS] = (hrs == a_hrs);
  assign field_eq[`CCA_AEN_DOM] = (dom == a_dom);
  assign field_eq[`CCA_AEN_MON] = (mon == a_mon);
  assign field_eq[`CCA_AEN_YR]  = (yr == a_yr);
  assign fire = cmp_pending && (&(field_eq | ~alarm_field_enables)); // R7

  // status and enable are control state and keep their value too
  always_ff @(posedge clk) begin
    if (fire) begin
      status <= 1'b1; // R8
    end else if (is_write(`CCA_OFS_CTRL) && pwdata[`CCA_CTRL_STATUS]) begin
      status <= 1'b0; // R9
    end
    if (is_write(`CCA_OFS_CTRL)) begin
      int_en <= pwdata[`CCA_CTRL_INT_EN];
    end
  end

  assign alarm_irq = status && int_en; // R8

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      power_management_unit_wake <= 1'b0;
    end else begin
      power_management_unit_wake <= fire; // R12
    end
  end

  always_comb begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    case (paddr)
      `CCA_OFS_SEC:   next_prdata[5:0] = sec; // R15
      `CCA_OFS_MIN:   next_prdata[5:0] = min;
      `CCA_OFS_HRS:   next_prdata[4:0] = hrs;
      `CCA_OFS_DOM:   next_prdata[4:0] = dom;
      `CCA_OFS_MON:   next_prdata[3:0] = mon;
      `CCA_OFS_YR:    next_prdata[7:0] = yr;
      `CCA_OFS_TIME:  next_prdata = {yr[5:0], mon, dom, hrs, min, sec}; // R3
      `CCA_OFS_ASEC:  next_prdata[5:0] = a_sec;
      `CCA_OFS_AMIN:  next_prdata[5:0] = a_min;
      `CCA_OFS_AHRS:  next_prdata[4:0] = a_hrs;
      `CCA_OFS_ADOM:  next_prdata[4:0] = a_dom;
      `CCA_OFS_AMON:  next_prdata[3:0] = a_mon;
      `CCA_OFS_AYR:   next_prdata[7:0] = a_yr;
      `CCA_OFS_ACTRL: next_prdata[5:0] = alarm_field_enables;
      `CCA_OFS_CTRL: begin
        next_prdata[`CCA_CTRL_INT_EN] = int_en;
        next_prdata[`CCA_CTRL_STATUS] = status;
      end
      default:        next_pslverr = 1'b1;
    endcase
  end

  // sampled in the setup phase so data is steady through the access phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence sec_rollover_s;
    tick && (sec == `CCA_SEC_LAST) && !is_write(`CCA_OFS_SEC)
      && !is_write(`CCA_OFS_MIN) && (min < `CCA_MIN_LAST);
  endsequence

  sequence alarm_hit_s;
    fire ##1 power_management_unit_wake;
  endsequence

  sec_roll_a: assert property (sec_rollover_s |=> // R15
    (sec == 6'h00) && (min == $past(min) + 6'h01))
    else $error("seconds did not roll into minutes");

  sec_step_a: assert property (tick && (sec < `CCA_SEC_LAST) // R21
    && !is_write(`CCA_OFS_SEC) |=> sec == $past(sec) + 6'h01)
    else $error("seconds did not advance on tick");

  hrs_wrap_a: assert property (c_hrs && !is_write(`CCA_OFS_HRS) // R17
    |=> hrs == 5'h00)
    else $error("hours did not wrap after 23");

  dom_wrap_a: assert property (c_dom && !is_write(`CCA_OFS_DOM) // R2
    && !is_write(`CCA_OFS_MON) |=> dom == `CCA_DOM_FIRST
    && (mon != $past(mon)))
    else $error("day did not wrap into next month");

  mon_wrap_a: assert property (c_mon && !is_write(`CCA_OFS_MON) // R19
    |=> mon == `CCA_MON_FIRST)
    else $error("month did not wrap to january");

  lock_hold_a: assert property (psel && penable && pwrite // R6
    && write_lock |=> $stable(alarm_field_enables) && $stable(a_yr))
    else $error("write taken while locked");

  match_fire_a: assert property (fire |-> $past(tick) // R11
    && ((alarm_field_enables & ~field_eq) == 6'h00))
    else $error("alarm fired without tick or match");

  fire_status_a: assert property (fire |=> status) // R8
    else $error("alarm status not set");

  irq_gate_a: assert property (!int_en |-> !alarm_irq) // R8
    else $error("irq raised while disabled");

  status_clr_a: assert property (is_write(`CCA_OFS_CTRL) // R9
    && pwdata[`CCA_CTRL_STATUS] && !fire |=> !status)
    else $error("status not cleared by one");

  wake_seq_a: assert property (fire |-> alarm_hit_s) // R12
    else $error("wake not sent on alarm");

  packed_rd_a: assert property (psel && !penable // R3
    && (paddr == `CCA_OFS_TIME) |=> prdata == {$past(yr[5:0]),
    $past(mon), $past(dom), $past(hrs), $past(min), $past(sec)})
    else $error("packed time word wrong");

  rsvd_zero_a: assert property (psel && !penable // R15
    && (paddr == `CCA_OFS_SEC) |=> prdata[31:6] == 26'h0)
    else $error("reserved bits not zero");

  min_wrap_a: assert property (c_min && !is_write(`CCA_OFS_MIN) // R16
    |=> min == 6'h00)
    else $error("minutes did not wrap after 59");

  yr_step_a: assert property (c_mon && !is_write(`CCA_OFS_YR) // R20
    |=> yr == $past(yr) + 8'h01)
    else $error("year did not advance after december");

  hrs_block_a: assert property (cmp_pending // R7
    && alarm_field_enables[`CCA_AEN_HRS] && (hrs != a_hrs) |-> !fire)
    else $error("alarm fired on mismatched enabled field");

  irq_follow_a: assert property (status && int_en |-> alarm_irq) // R8
    else $error("irq missing while status and enable set");

  wake_src_a: assert property (power_management_unit_wake // R12
    |-> $past(fire))
    else $error("wake pulse without alarm");

  lock_time_a: assert property (psel && penable && pwrite // R6
    && write_lock && !tick |=> $stable(sec) && $stable(yr))
    else $error("time write taken while locked");
endmodule
`default_nettype wire

// ### testbench/cca_cpu.sv
`timescale 1ns/10ps
`default_nettype none
module cca_cpu (
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [32:0] q);
    @(negedge clk);
    psel = 1'h1;
    pwrite = w;
    paddr = a;
    pwdata = d;
    @(negedge clk);
    penable = 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    q = {pslverr, prdata};
    @(negedge clk);
    psel = 1'h0;
    penable = 1'h0;
    // released data lines must not keep the old value
    pwdata = ~d;
  endtask
  // timebase is asynchronous to the bus, so a single read may tear
  task automatic rd_v(input logic [11:0] a, output logic [32:0] q);
    logic [32:0] p;
    xfer(1'h0, a, 32'h0, p);
    for (int i = 0; i < 8; i++) begin
      xfer(1'h0, a, 32'h0, q);
      if (q === p) break;
      p = q;
    end
  endtask
  task automatic wr_v(input logic [11:0] a, input logic [31:0] d);
    logic [32:0] q;
    for (int i = 0; i < 8; i++) begin
      xfer(1'h1, a, d, q);
      xfer(1'h0, a, 32'h0, q);
      if (q[31:0] === d) break;
    end
  endtask
endmodule
`default_nettype wire

// ### testbench/calendar_clock_alarm_test.sv
`timescale 1ns/10ps
`default_nettype none
module calendar_clock_alarm_test;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        osc_32k = 1'h0;
  logic        osc_run = 1'h0;
  logic        write_lock = 1'h0;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        pready;
  logic        pslverr;
  logic        alarm_irq;
  logic        wake;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [32:0] got_v;
  logic [32:0] q;
  logic [32:0] exp_q[$];
  logic        wake_q[$];
  logic [31:0] seed = 32'hfdc1;
  int          num_errors = 0;
  int          tests_run = 0;
  int          cyc = 0;
  event        got;
  logic [7:0]  msk[14] = '{8'h3f, 8'h3f, 8'h1f, 8'h1f, 8'h0f, 8'hff, 8'h0,
                           8'h3f, 8'h3f, 8'h1f, 8'h1f, 8'h0f, 8'hff, 8'h3f};
  logic [33:0] cs[5] = '{{8'h64, 4'h2, 5'h1c, 8'h64, 4'h2, 5'h1d},
                         {8'h65, 4'h2, 5'h1c, 8'h65, 4'h3, 5'h01},
                         {8'hff, 4'hc, 5'h1f, 8'h00, 4'h1, 5'h01},
                         {8'h00, 4'h2, 5'h1c, 8'h00, 4'h2, 5'h1d},
                         {8'h64, 4'h4, 5'h1e, 8'h64, 4'h5, 5'h01}};

  always #5 clk = ~clk;
  // oscillator only runs in chosen windows so register tests stay exact
  always #30 if (osc_run) osc_32k = ~osc_32k;

  cca_top #(.TICK_DIV(4)) DUT (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_32k(osc_32k),
    .write_lock(write_lock), .alarm_irq(alarm_irq),
    .power_management_unit_wake(wake));
  cca_cpu cpu (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string n, input logic [32:0] e,
                     input logic [32:0] s);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wrap_up();
    if (num_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    cpu.xfer(1'h0, a, 32'h0, got_v);
    ->got;
  endtask
  task automatic set_t(input logic [7:0] y, input logic [3:0] m,
    input logic [4:0] d, input logic [4:0] h, input logic [5:0] n,
    input logic [5:0] s);
    cpu.wr_v(12'h014, {24'h0, y});
    cpu.wr_v(12'h010, {28'h0, m});
    cpu.wr_v(12'h00c, {27'h0, d});
    cpu.wr_v(12'h008, {27'h0, h});
    cpu.wr_v(12'h004, {26'h0, n});
    cpu.wr_v(12'h000, {26'h0, s});
  endtask
  task automatic run_until(input logic [11:0] a, input int b,
                           input logic v);
    osc_run = 1'h1;
    q = {33{~v}};
    for (int k = 0; k < 80 && q[b] !== v; k++) cpu.rd_v(a, q);
    osc_run = 1'h0;
  endtask

  always @(got) chk("read", exp_q.pop_front(), got_v);
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      wrap_up();
    end
  end
  // wake is a one-cycle pulse from a flop, so look at it mid-cycle
  always @(negedge clk) begin
    if (wake === 1'h1)
      chk("wake", wake_q.size() ? wake_q.pop_front() : 33'h0, 33'h1);
  end

  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk) rst = 1'h0;
    for (int i = 0; i < 14; i++) begin
      q[31:0] = rnd();
      if (i != 6) begin
        cpu.xfer(1'h1, 12'(4 * i), q[31:0], got_v);
        rd(12'(4 * i), {25'h0, q[7:0] & msk[i]});
      end
    end
    rd(12'h040, {1'h1, 32'h0});
    cpu.wr_v(12'h01c, 32'h1e);
    cpu.wr_v(12'h034, 32'h1);
    cpu.xfer(1'h1, 12'h038, 32'h2, got_v);
    cpu.wr_v(12'h000, 32'h5);
    write_lock = 1'h1;
    cpu.xfer(1'h1, 12'h000, 32'h7, got_v);
    write_lock = 1'h0;
    rd(12'h000, 33'h5);
    rst = 1'h1;
    repeat (2) @(negedge clk);
    rst = 1'h0;
    rd(12'h000, 33'h5);
    for (int i = 0; i < 5; i++) begin
      set_t(cs[i][33:26], cs[i][25:22], cs[i][21:17], 5'h17, 6'h3b, 6'h3b);
      run_until(12'h018, 3, 1'h0);
      exp_q.push_back({1'h0, cs[i][14:9], cs[i][8:0], 17'h0});
      got_v = q;
      ->got;
    end
    set_t(8'h65, 4'h7, 5'h15, 5'h13, 6'h2a, 6'h05);
    cpu.xfer(1'h1, 12'h018, 32'h0, got_v);
    rd(12'h018, {1'h0, 6'h25, 4'h7, 5'h15, 5'h13, 6'h2a, 6'h05});
    cpu.wr_v(12'h024, 32'hb);
    cpu.wr_v(12'h01c, 32'hb);
    cpu.wr_v(12'h034, 32'h5);
    cpu.wr_v(12'h000, 32'h3b);
    run_until(12'h000, 2, 1'h1);
    rd(12'h038, 33'h0);
    cpu.wr_v(12'h024, 32'h13);
    cpu.wr_v(12'h000, 32'ha);
    wake_q.push_back(1'h1);
    run_until(12'h038, 1, 1'h1);
    chk("irq", 33'h0, {32'h0, alarm_irq});
    rd(12'h038, 33'h2);
    cpu.xfer(1'h1, 12'h038, 32'h1, got_v);
    rd(12'h038, 33'h3);
    chk("irq", 33'h1, {32'h0, alarm_irq});
    cpu.xfer(1'h1, 12'h038, 32'h3, got_v);
    rd(12'h038, 33'h1);
    chk("irq", 33'h0, {32'h0, alarm_irq});
    // every field enabled, all matching the next second
    cpu.wr_v(12'h020, 32'h2b);
    cpu.wr_v(12'h028, 32'h15);
    cpu.wr_v(12'h02c, 32'h7);
    cpu.wr_v(12'h030, 32'h65);
    cpu.wr_v(12'h01c, 32'hc);
    cpu.wr_v(12'h034, 32'h3f);
    cpu.wr_v(12'h000, 32'hb);
    wake_q.push_back(1'h1);
    run_until(12'h038, 1, 1'h1);
    chk("irq", 33'h1, {32'h0, alarm_irq});
    cpu.xfer(1'h1, 12'h038, 32'h2, got_v);
    rd(12'h038, 33'h0);
    chk("irq", 33'h0, {32'h0, alarm_irq});
    chk("wake", 33'h1, {32'h0, wake_q.size() == 0});
    wrap_up();
  end
endmodule
`default_nettype wire
